/* File: core/eexs_slave.sv */
// Serial two-wire slave front end with row-buffered EEPROM writes.
// Assumes SCL/SDA come from pins; SDA is open drain driven via sda_oe.
//
// Function
// - Change SDA only after SCL falls.
// - Ninth bit is acknowledge, zero means ack.
// - Eight bits MSB first, then slave ack.
// - First byte after start is address byte.
// - Low address bits equal strap pins.
// - Flag zero writes, flag one reads.
// - Mismatch: stay off bus until start.
// - Second write byte loads address counter.
// - Up to eight bytes, address increments each.
// - Counter wraps within aligned 8-byte row.
// - After stop program; refuse address meanwhile.
// - Whole row programmed; unwritten bytes kept.
// - Read starts at current counter value.
// - Random read via dummy write, repeated start.
// - Multi-byte read returns successive locations.
// - Sample SDA on SCL rising edge.
// - Start is SDA fall, stop SDA rise, SCL high.
// - Inhibit bit: shadow row writes skip programming.
`timescale 1ns/10ps
module eexs_slave
    import eexs_pkg::*;
#(
    parameter int unsigned TW_CYC = TW_CYCLES   // Programming time in cycles
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Bus pins
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // Address straps
    input  wire logic addr_strap_bit0,
    input  wire logic addr_strap_bit1,
    input  wire logic addr_strap_bit2,
    // Status
    output logic      busy
);

    // Elaboration check: the countdown and the span check need a few cycles
    if (TW_CYC < 8) begin : g_bad_tw
        $error("TW_CYC must be at least eight");
    end

    eexs_pins_t pins_raw;           // Raw pin group before synchronising
    eexs_pins_t pins_now;           // Synchronised pins
    eexs_pins_t pins_prev;          // Previous synchronised sample
    eexs_regs_t r_q;                // Registered state
    eexs_regs_t r_d;                // Next state
    logic [7:0] mem [0:255];        // Visible memory and shadow
    logic       scl_rise;           // SCL edge events
    logic       scl_fall;
    logic       start_ev;           // Start and stop conditions
    logic       stop_ev;
    logic       addr_match;         // Address byte is ours
    logic       commit;             // Pending row goes to memory
    logic [7:0] rd_byte;            // Byte at the counter

    // Gather the asynchronous pins into one group
    assign pins_raw = '{scl: scl, sda: sda_i,
                        strap: {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}};

    // Pin synchroniser
    eexs_pin_sync u_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pins_raw  (pins_raw),
        .pins_now  (pins_now),
        .pins_prev (pins_prev)
    );

    // Edge and condition detection
    assign scl_rise = pins_now.scl & ~pins_prev.scl;
    assign scl_fall = ~pins_now.scl & pins_prev.scl;
    assign start_ev = pins_now.scl & pins_prev.scl & pins_prev.sda & ~pins_now.sda;
    assign stop_ev  = pins_now.scl & pins_prev.scl & ~pins_prev.sda & pins_now.sda;

    // Address compare against type nibble and straps, refused while busy
    assign addr_match = (r_q.shreg[7:4] == DEV_TYPE)
                      && (r_q.shreg[3:STRAP_LSB] == pins_now.strap)
                      && !r_q.busy;
    assign rd_byte = mem[r_q.addr];
    assign commit  = stop_ev && (r_q.pmask != 8'h00);

    // Next-state logic
    always_comb begin
        r_d = r_q;
        if (r_q.busy) begin
            // Programming countdown
            if (r_q.twcnt <= 32'h1) begin
                r_d.busy  = 1'b0;
                r_d.twcnt = 32'h0;
            end else begin
                r_d.twcnt = r_q.twcnt - 32'h1;
            end
        end
        if (start_ev) begin
            // Any start, also repeated: expect address byte
            r_d.st     = S_ADDR;
            r_d.bitcnt = 4'h0;
            r_d.sda_oe = 1'b0;
        end else if (stop_ev) begin
            r_d.st     = S_IDLE;
            r_d.sda_oe = 1'b0;
            r_d.pmask  = 8'h00;
            // Inhibited shadow-row writes touch memory only
            if (commit && !(mem[CFG_LOC][INHIBIT_POS] && r_q.prow == SHADOW_ROW)) begin
                r_d.busy  = 1'b1;
                r_d.twcnt = 32'(TW_CYC);
            end
        end else if (scl_rise) begin
            case (r_q.st)
                // Shift in receive bits MSB first
                S_ADDR, S_LOC, S_WDATA: begin
                    r_d.shreg  = {r_q.shreg[6:0], pins_now.sda};
                    r_d.bitcnt = r_q.bitcnt + 4'h1;
                end
                // Master nack ends the read
                S_RACK: begin
                    if (pins_now.sda) begin
                        r_d.st = S_IGNORE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (r_q.st)
                // Address byte complete
                S_ADDR: begin
                    if (r_q.bitcnt == 4'h8) begin
                        if (addr_match) begin
                            r_d.st     = S_ADDR_ACK;
                            r_d.rw     = r_q.shreg[RW_POS];
                            r_d.sda_oe = 1'b1;
                        end else begin
                            r_d.st = S_IGNORE;
                        end
                    end
                end
                // End of address ack: read starts or location follows
                S_ADDR_ACK: begin
                    r_d.bitcnt = (r_q.rw) ? 4'h1 : 4'h0;
                    if (r_q.rw) begin
                        r_d.st     = S_RDATA;
                        r_d.txbyte = rd_byte;
                        r_d.sda_oe = ~rd_byte[7];
                    end else begin
                        r_d.st     = S_LOC;
                        r_d.sda_oe = 1'b0;
                    end
                end
                // Location byte loads the counter
                S_LOC: begin
                    if (r_q.bitcnt == 4'h8) begin
                        r_d.addr   = r_q.shreg;
                        r_d.prow   = r_q.shreg[7:3];
                        r_d.pmask  = 8'h00;
                        r_d.st     = S_LOC_ACK;
                        r_d.sda_oe = 1'b1;
                    end
                end
                // Data byte into the row buffer, counter wraps in row
                S_WDATA: begin
                    if (r_q.bitcnt == 4'h8) begin
                        r_d.pagebuf[r_q.addr[2:0]*8 +: 8] = r_q.shreg;
                        r_d.pmask[r_q.addr[2:0]] = 1'b1;
                        r_d.addr   = {r_q.addr[7:3], r_q.addr[2:0] + 3'h1};
                        r_d.st     = S_WACK;
                        r_d.sda_oe = 1'b1;
                    end
                end
                // Release after our ack
                S_LOC_ACK, S_WACK: begin
                    r_d.st     = S_WDATA;
                    r_d.bitcnt = 4'h0;
                    r_d.sda_oe = 1'b0;
                end
                // Send next bit, or release for master ack
                S_RDATA: begin
                    if (r_q.bitcnt == 4'h8) begin
                        r_d.st     = S_RACK;
                        r_d.sda_oe = 1'b0;
                        r_d.addr   = r_q.addr + 8'h1;
                    end else begin
                        r_d.sda_oe = ~r_q.txbyte[3'(7 - r_q.bitcnt)];
                        r_d.bitcnt = r_q.bitcnt + 4'h1;
                    end
                end
                // Master acked: next location
                S_RACK: begin
                    r_d.st     = S_RDATA;
                    r_d.txbyte = rd_byte;
                    r_d.sda_oe = ~rd_byte[7];
                    r_d.bitcnt = 4'h1;
                end
                default: begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            r_q <= '{st: S_IDLE, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // Memory update at stop: only written bytes of the row change
    always_ff @(posedge sys_clk) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (r_q.pmask[i]) begin
                    mem[{r_q.prow, 3'(i)}] <= r_q.pagebuf[i*8 +: 8];
                end
            end
        end
    end

    // Outputs straight from flip-flops; SDA only ever pulled low
    assign sda_oe = r_q.sda_oe;
    assign busy   = r_q.busy;
    assign sda_o  = r_q.sda_oe & 1'b0;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_start_to_addr: assert property (start_ev |=> r_q.st == S_ADDR)
        else $error("start did not open address phase");
    chk_addr_ack_drive: assert property (
        (r_q.st == S_ADDR && scl_fall && r_q.bitcnt == 4'h8 && !start_ev && !stop_ev
         && addr_match) |=> r_q.sda_oe ##1 r_q.st == S_ADDR_ACK)
        else $error("matching address not acknowledged");
    chk_ignore_silent: assert property (r_q.st == S_IGNORE |-> !r_q.sda_oe)
        else $error("sda driven while ignoring");
    chk_busy_refuse: assert property (
        (r_q.busy && r_q.st == S_ADDR && scl_fall && r_q.bitcnt == 4'h8 && !start_ev
         && !stop_ev) |=> r_q.st == S_IGNORE && !r_q.sda_oe)
        else $error("address accepted while programming");
    chk_sda_on_fall: assert property (
        $changed(r_q.sda_oe) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
        else $error("sda changed outside scl low");
    chk_loc_load: assert property (
        (r_q.st == S_LOC && scl_fall && r_q.bitcnt == 4'h8 && !start_ev && !stop_ev)
        |=> r_q.addr == $past(r_q.shreg))
        else $error("location not loaded");
    chk_row_wrap: assert property (
        (r_q.st == S_WDATA && scl_fall && r_q.bitcnt == 4'h8 && !start_ev && !stop_ev)
        |=> r_q.addr[7:3] == $past(r_q.addr[7:3])
            && r_q.addr[2:0] == $past(r_q.addr[2:0]) + 3'h1)
        else $error("counter left its row");
    chk_rx_sample: assert property (
        (r_q.st == S_ADDR && scl_rise && !start_ev && !stop_ev)
        |=> r_q.shreg[0] == $past(pins_now.sda))
        else $error("bit not sampled on rise");
    chk_nack_release: assert property (
        (r_q.st == S_RACK && scl_rise && pins_now.sda && !start_ev && !stop_ev)
        |=> r_q.st == S_IGNORE ##1 !r_q.sda_oe)
        else $error("nack did not end read");
    chk_busy_span: assert property ($rose(r_q.busy) |-> r_q.busy [*8])
        else $error("programming ended too soon");

endmodule : eexs_slave

/* File: core/eexs_pkg.sv */
// Shared constants, states and carriers for the expander serial slave.
// Assumes a single 200 MHz system clock; bus pins arrive asynchronously.
package eexs_pkg;

    // Clock and EEPROM write time
    localparam int unsigned CLK_PERIOD_NS = 5;          // System clock period
    localparam int unsigned TW_NS         = 10000000;   // EEPROM write time
    localparam int unsigned TW_CYCLES     = TW_NS / CLK_PERIOD_NS;

    // Address byte layout
    localparam logic [3:0] DEV_TYPE   = 4'hA;           // Fixed device-type nibble
    localparam int unsigned RW_POS    = 0;              // Read/write flag position
    localparam int unsigned STRAP_LSB = 1;              // Strap bits start here

    // Memory layout
    localparam int unsigned PAGE_BYTES = 8;             // One aligned row
    localparam logic [7:0] CFG_LOC     = 8'hF4;         // Configuration location
    localparam int unsigned INHIBIT_POS = 0;            // Inhibit bit in config
    localparam logic [4:0] SHADOW_ROW  = 5'h1E;         // Row holding F0h..F7h

    // Synchronised pin group
    typedef struct packed {
        logic       scl;        // Serial clock
        logic       sda;        // Serial data
        logic [2:0] strap;      // Address straps, bit0 first
    } eexs_pins_t;

    // Protocol states
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_LOC, S_LOC_ACK,
        S_WDATA, S_WACK, S_RDATA, S_RACK, S_IGNORE
    } eexs_state_t;

    // Whole state of the slave
    typedef struct packed {
        eexs_state_t st;        // Protocol state
        logic [7:0]  shreg;     // Receive shift register
        logic [3:0]  bitcnt;    // Bits moved in this byte
        logic        rw;        // Read flag of the current transfer
        logic [7:0]  addr;      // Memory address counter
        logic [63:0] pagebuf;   // Pending row data
        logic [7:0]  pmask;     // Bytes written in pending row
        logic [4:0]  prow;      // Pending row number
        logic [7:0]  txbyte;    // Byte being sent
        logic        sda_oe;    // Pull SDA low
        logic        busy;      // EEPROM programming
        logic [31:0] twcnt;     // Programming countdown
    } eexs_regs_t;

endpackage : eexs_pkg

/* File: core/eexs_pin_sync.sv */
// Two-flop synchroniser for the bus pins plus one history stage.
// Assumes pins are asynchronous to sys_clk; reset is synchronous active low.
`timescale 1ns/10ps
module eexs_pin_sync
    import eexs_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Raw pins
    input  wire eexs_pins_t pins_raw,
    // Synchronised value and its previous sample
    output eexs_pins_t      pins_now,
    output eexs_pins_t      pins_prev
);

    eexs_pins_t meta_q;     // First stage, read only by the second

    // Three-deep shift; idle bus level is high
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            meta_q    <= '{scl: 1'b1, sda: 1'b1, strap: 3'h0};
            pins_now  <= '{scl: 1'b1, sda: 1'b1, strap: 3'h0};
            pins_prev <= '{scl: 1'b1, sda: 1'b1, strap: 3'h0};
        end else begin
            meta_q    <= pins_raw;
            pins_now  <= meta_q;
            pins_prev <= pins_now;
        end
    end

endmodule : eexs_pin_sync

/* File: test/eexs_master.sv */
// Behavioural two-wire bus master that drives SCL and pulls SDA low.
// Assumes a pull-up on SDA in the bench and the system clock for pacing.
`timescale 1ns/10ps
module eexs_master (
    // Pacing clock
    input  wire logic sys_clk,
    // Bus wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // Bus idle at time zero
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Wait n system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // One bus clock of 125 ns: data moves while SCL is low, read mid-high
    task automatic bit_io(input logic b, output logic r);
        tick(6);
        sda_low <= ~b;
        tick(6);
        scl     <= 1'b1;
        tick(7);
        r = sda;
        tick(6);
        scl     <= 1'b0;
    endtask : bit_io
    // Start or repeated start: SDA falls with SCL high
    task automatic start();
        tick(6);
        sda_low <= 1'b0;
        tick(6);
        scl     <= 1'b1;
        tick(6);
        sda_low <= 1'b1;
        tick(6);
        scl     <= 1'b0;
    endtask : start
    // Stop: SDA rises with SCL high, then bus idle
    task automatic stop();
        tick(6);
        sda_low <= 1'b1;
        tick(6);
        scl     <= 1'b1;
        tick(6);
        sda_low <= 1'b0;
        tick(12);
    endtask : stop
    // Eight bits MSB first, then read the slave's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack);
    endtask : wbyte
    // Read eight bits, then ack for more or nack the last one
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : rbyte
endmodule : eexs_master

/* File: test/eexs_slave_tb.sv */
// Self-checking bench for the serial slave: writes, polling, reads, misses.
// Assumes the master model on the bus and a pull-up on SDA.
`timescale 1ns/10ps
module eexs_slave_tb;
    import eexs_pkg::*;
    localparam int TWC = 600;           // Short programming time
    logic       sys_clk  = 1'b0;        // System clock
    logic       reset_n  = 1'b0;        // Reset, active low
    logic [2:0] strap    = 3'h0;        // Address straps
    logic       scl, sda_low, sda_o, sda_oe, busy;
    wire  logic sda      = ~(sda_low | (sda_oe & ~sda_o));   // Pulled-up wire
    logic [7:0] mem [256];              // Expected memory
    logic       vld [256];              // Location written
    int         n_errors = 0;
    int         compares = 0;
    int         seed     = 32'h6FE3;
    logic       quiet    = 1'b0;        // Device must stay off the bus
    logic       oe_p     = 1'b0;
    logic       scl_p    = 1'b1;
    logic [7:0] loc, a, d, base, bad;
    logic       ack;
    int         n, polls;

    eexs_slave #(.TW_CYC(TWC)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
        .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .busy(busy));
    eexs_master u_m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    // Clock generator
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    // Verdict and end of run
    task automatic end_sim();
        $display("Compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // Expected slave address byte
    function automatic logic [7:0] dev(input logic rd);
        return {DEV_TYPE, strap, rd};
    endfunction : dev
    // Send a byte and check the acknowledge
    task automatic put(input logic [7:0] b, input logic nack);
        logic r;
        u_m.wbyte(b, r);
        chk(8'(r), 8'(nack));
    endtask : put
    // SDA driven by the device moves only while SCL is low; silent when missed
    always @(posedge sys_clk) begin
        if (reset_n && sda_oe !== oe_p && scl_p === 1'b1 && scl === 1'b1) begin
            chk(8'(sda_oe), 8'(oe_p));
        end
        if (quiet) begin
            chk(8'(sda_oe), 8'h00);
        end
        oe_p  <= sda_oe;
        scl_p <= scl;
    end
    // Watchdog: about twice the expected length of the run
    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        foreach (vld[i]) vld[i] = 1'b0;
        u_m.tick(8);
        reset_n <= 1'b1;
        u_m.tick(8);
        for (int it = 0; it < 6; it++) begin
            strap <= 3'($random(seed));
            u_m.tick(8);
            loc = 8'($random(seed)) & 8'h7F;
            n   = 1 + ($random(seed) & 7);
            if (it == 0) begin
                loc = 8'h06;
                n   = 8;
            end else if (it == 1) begin
                n   = 10;
            end else if (it == 2) begin
                loc = 8'h03;
                n   = 1;
            end
            u_m.start();
            put(dev(1'b0), 1'b0);
            put(loc, 1'b0);
            a = loc;
            for (int i = 0; i < n; i++) begin
                d = 8'($random(seed));
                put(d, 1'b0);
                mem[a] = d;
                vld[a] = 1'b1;
                a = {a[7:3], a[2:0] + 3'h1};
            end
            u_m.stop();
            u_m.tick(2);
            chk(8'(busy), 8'h01);
            polls = 0;
            ack   = 1'b1;
            while (ack === 1'b1 && polls < 20) begin
                u_m.start();
                u_m.wbyte(dev(1'b0), ack);
                u_m.stop();
                polls++;
            end
            chk(8'(polls > 1), 8'h01);
            chk(8'(ack), 8'h00);
            base = {loc[7:3], 3'h0};
            u_m.start();
            put(dev(1'b0), 1'b0);
            put(base, 1'b0);
            u_m.start();
            put(dev(1'b1), 1'b0);
            for (int i = 0; i < 8; i++) begin
                if (i == 4) begin
                    u_m.stop();
                    u_m.start();
                    put(dev(1'b1), 1'b0);
                end
                u_m.rbyte(i == 3 || i == 7, d);
                if (vld[base + 8'(i)]) chk(d, mem[base + 8'(i)]);
            end
            u_m.stop();
        end
        // Inhibit set in the shadow row: later row writes skip programming
        u_m.start();
        put(dev(1'b0), 1'b0);
        put(CFG_LOC, 1'b0);
        put(8'h01, 1'b0);
        u_m.stop();
        u_m.tick(TWC + 20);
        d = 8'($random(seed));
        u_m.start();
        put(dev(1'b0), 1'b0);
        put(CFG_LOC + 8'h01, 1'b0);
        put(d, 1'b0);
        u_m.stop();
        u_m.tick(2);
        chk(8'(busy), 8'h00);
        u_m.start();
        put(dev(1'b0), 1'b0);
        put(CFG_LOC, 1'b0);
        u_m.start();
        put(dev(1'b1), 1'b0);
        u_m.rbyte(1'b0, a);
        chk(a, 8'h01);
        u_m.rbyte(1'b1, a);
        chk(a, d);
        u_m.stop();
        for (int k = 0; k < 4; k++) begin
            bad = dev(k[0]) ^ ((k < 3) ? (8'h02 << k) : 8'h80);
            u_m.start();
            quiet = 1'b1;
            put(bad, 1'b1);
            put(8'h00, 1'b1);
            u_m.stop();
            quiet = 1'b0;
        end
        end_sim();
    end
endmodule : eexs_slave_tb
